// file: rtl/kbd_cmd_pkg.sv
// Package of command codes, result codes, bit positions and timing counts for the decoder.
package kbd_cmd_pkg;
  localparam logic [7:0] CMD_AUX_DISABLE = 8'hA7;
  localparam logic [7:0] CMD_AUX_ENABLE  = 8'hA8;
  localparam logic [7:0] CMD_AUX_CHECK   = 8'hA9;
  localparam logic [7:0] CMD_SELF_TEST   = 8'hAA;
  localparam logic [7:0] CMD_KBD_CHECK   = 8'hAB;
  localparam logic [7:0] CMD_KBD_DISABLE = 8'hAD;
  localparam logic [7:0] CMD_KBD_ENABLE  = 8'hAE;
  localparam logic [7:0] CMD_READ_INPUT  = 8'hC0;

  localparam logic [7:0] CHK_OK          = 8'h00;
  localparam logic [7:0] CHK_CLK_LOW     = 8'h01;
  localparam logic [7:0] CHK_CLK_HIGH    = 8'h02;
  localparam logic [7:0] CHK_DAT_LOW     = 8'h03;
  localparam logic [7:0] CHK_DAT_HIGH    = 8'h04;

  localparam logic [7:0] SELF_TEST_PASS  = 8'h55;
  localparam logic [3:0] ERR_CMD_CHECK   = 4'h1;
  localparam logic [3:0] ERR_INSTR       = 4'h2;
  localparam logic [3:0] ERR_RAM         = 4'h3;
  localparam logic [3:0] ERR_ROM         = 4'h4;
  localparam logic [3:0] ERR_TIMER       = 4'h5;
  localparam logic [3:0] ERR_INIT        = 4'h6;
  localparam logic [3:0] ERR_PASS_DONE   = 4'h8;
  localparam logic [3:0] ERR_NONE        = 4'h0;

  localparam int         KBD_DIS_BIT     = 4;
  localparam int         AUX_DIS_BIT     = 5;
  localparam logic [7:0] CMD_BYTE_RESET  = 8'h00;

  localparam int         CLK_HZ          = 100_000_000;
  localparam int         SETTLE_NS       = 1000;
  localparam int         SETTLE_CYCLES   = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int         SELF_TEST_CYCLES = 16;
endpackage

// file: rtl/line_check_if.sv
// Interface carrying a line-check request and its result between decoder and checker.
interface line_check_if;
  logic       start;
  logic       sel_aux;
  logic       busy;
  logic       done;
  logic [7:0] code;
  logic       drive_clk_low;
  logic       drive_dat_low;
  modport ctrl (output start, output sel_aux, input busy, input done, input code);
  modport chk  (input start, input sel_aux, output busy, output done, output code,
                output drive_clk_low, output drive_dat_low);
  modport pins (input drive_clk_low, input drive_dat_low, input sel_aux);
endinterface

// file: rtl/line_checker.sv
// Stuck-line checker: pulls each line low, then releases it, and watches the synced level.
module line_checker #(
  parameter int SETTLE = kbd_cmd_pkg::SETTLE_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  input  wire logic clk_level,
  input  wire logic dat_level,
  line_check_if.chk lc
);
  typedef enum logic [2:0] {IDLE, CLK_PULL, CLK_REL, DAT_PULL, DAT_REL, DONE} chk_state_t;
  chk_state_t  state;
  chk_state_t  next_state;
  logic [15:0] cnt;
  logic [15:0] next_cnt;
  logic [7:0]  code;
  logic [7:0]  next_code;
  logic        timeout;

  assign timeout = (cnt == 16'(SETTLE - 1));

  // Each phase waits the settle time before sampling, then either fails or moves on.
  always_comb begin
    next_state = state;
    next_cnt   = timeout ? 16'h0000 : cnt + 16'h0001;
    next_code  = code;
    case (state)
      IDLE: begin
        next_cnt = 16'h0000;
        if (lc.start) begin
          next_state = CLK_PULL;
        end
      end
      CLK_PULL: if (timeout) begin
        next_state = clk_level ? DONE : CLK_REL;
        next_code  = kbd_cmd_pkg::CHK_CLK_HIGH;
      end
      CLK_REL: if (timeout) begin
        next_state = clk_level ? DAT_PULL : DONE;
        next_code  = kbd_cmd_pkg::CHK_CLK_LOW;
      end
      DAT_PULL: if (timeout) begin
        next_state = dat_level ? DONE : DAT_REL;
        next_code  = kbd_cmd_pkg::CHK_DAT_HIGH;
      end
      DAT_REL: if (timeout) begin
        next_state = DONE;
        next_code  = dat_level ? kbd_cmd_pkg::CHK_OK : kbd_cmd_pkg::CHK_DAT_LOW;
      end
      DONE:    next_state = IDLE;
      default: next_state = IDLE;
    endcase
  end

  // State registers.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= IDLE;
      cnt   <= 16'h0000;
      code  <= 8'h00;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      code  <= next_code;
    end
  end

  assign lc.busy          = (state != IDLE);
  assign lc.done          = (state == DONE);
  assign lc.code          = code;
  assign lc.drive_clk_low = (state == CLK_PULL);
  assign lc.drive_dat_low = (state == DAT_PULL);
endmodule

// file: rtl/kbd_mouse_cmd_decode.sv
// Keyboard/mouse controller command decoder with line checks, self-test and input-port read.
module kbd_mouse_cmd_decode #(
  parameter int SETTLE = kbd_cmd_pkg::SETTLE_CYCLES,
  parameter int ST_CYC = kbd_cmd_pkg::SELF_TEST_CYCLES
) (
  input  wire logic       ref_clk,
  input  wire logic       arst_n,
  input  wire logic       cmd_write,
  input  wire logic [7:0] cmd_data,
  input  wire logic       out_read,
  input  wire logic [7:0] input_port,
  input  wire logic       self_test_fault,
  input  wire logic [3:0] self_test_fault_code,
  input  wire logic       kbd_clk_in,
  input  wire logic       kbd_dat_in,
  input  wire logic       aux_clk_in,
  input  wire logic       aux_dat_in,
  output logic            kbd_clk_oe_n,
  output logic            kbd_dat_oe_n,
  output logic            aux_clk_oe_n,
  output logic            aux_dat_oe_n,
  output logic            kbd_clk_out,
  output logic            kbd_dat_out,
  output logic            aux_clk_out,
  output logic            aux_dat_out,
  output logic [7:0]      out_data,
  output logic            output_full_flag,
  output logic [3:0]      status_code,
  output logic [7:0]      command_byte,
  output logic            kbd_enabled,
  output logic            busy
);
  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, a level counts once stages two and three agree.
  logic [2:0] s_kc;
  logic [2:0] s_kd;
  logic [2:0] s_ac;
  logic [2:0] s_ad;
  logic [3:0] lvl;
  logic [3:0] next_lvl;

  // Debounced levels update only when the last two stages agree.
  always_comb begin
    next_lvl = lvl;
    if (s_kc[1] == s_kc[2]) next_lvl[0] = s_kc[2];
    if (s_kd[1] == s_kd[2]) next_lvl[1] = s_kd[2];
    if (s_ac[1] == s_ac[2]) next_lvl[2] = s_ac[2];
    if (s_ad[1] == s_ad[2]) next_lvl[3] = s_ad[2];
  end

  // Synchroniser registers; lines idle high.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_kc <= 3'h7;
      s_kd <= 3'h7;
      s_ac <= 3'h7;
      s_ad <= 3'h7;
      lvl  <= 4'hF;
    end else begin
      s_kc <= {s_kc[1:0], kbd_clk_in};
      s_kd <= {s_kd[1:0], kbd_dat_in};
      s_ac <= {s_ac[1:0], aux_clk_in};
      s_ad <= {s_ad[1:0], aux_dat_in};
      lvl  <= next_lvl;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line checker shared by both interfaces.
  line_check_if lc ();
  logic chk_clk;
  logic chk_dat;

  assign chk_clk = lc.sel_aux ? lvl[2] : lvl[0];
  assign chk_dat = lc.sel_aux ? lvl[3] : lvl[1];

  line_checker #(.SETTLE(SETTLE)) u_chk (
    .ref_clk   (ref_clk),
    .arst_n    (arst_n),
    .clk_level (chk_clk),
    .dat_level (chk_dat),
    .lc        (lc.chk)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Command sequencer.
  typedef enum logic [1:0] {IDLE, CHECK, SELF_TEST} seq_state_t;
  seq_state_t  state;
  seq_state_t  next_state;
  logic [7:0]  cmd_reg;
  logic [7:0]  next_cmd_reg;
  logic [7:0]  out_reg;
  logic [7:0]  next_out_reg;
  logic        full;
  logic        next_full;
  logic [3:0]  st_code;
  logic [3:0]  next_st_code;
  logic        st_done;
  logic        next_st_done;
  logic        sel_aux;
  logic        next_sel_aux;
  logic        chk_start;
  logic        next_chk_start;
  logic [15:0] st_cnt;
  logic [15:0] next_st_cnt;
  logic        load;

  // Decode a command on its write strobe only while idle; results other than a self-test fault load the output register.
  always_comb begin
    next_state     = state;
    next_cmd_reg   = cmd_reg;
    next_out_reg   = out_reg;
    next_st_code   = st_code;
    next_st_done   = st_done;
    next_sel_aux   = sel_aux;
    next_chk_start = 1'b0;
    next_st_cnt    = st_cnt;
    load           = 1'b0;
    case (state)
      IDLE: begin
        if (cmd_write) begin
          case (cmd_data)
            kbd_cmd_pkg::CMD_AUX_DISABLE: next_cmd_reg[kbd_cmd_pkg::AUX_DIS_BIT] = 1'b1;
            kbd_cmd_pkg::CMD_AUX_ENABLE:  next_cmd_reg[kbd_cmd_pkg::AUX_DIS_BIT] = 1'b0;
            kbd_cmd_pkg::CMD_KBD_DISABLE: next_cmd_reg[kbd_cmd_pkg::KBD_DIS_BIT] = 1'b1;
            kbd_cmd_pkg::CMD_KBD_ENABLE:  next_cmd_reg[kbd_cmd_pkg::KBD_DIS_BIT] = 1'b0;
            kbd_cmd_pkg::CMD_AUX_CHECK, kbd_cmd_pkg::CMD_KBD_CHECK: begin
              next_sel_aux   = (cmd_data == kbd_cmd_pkg::CMD_AUX_CHECK);
              next_chk_start = 1'b1;
              next_state     = CHECK;
            end
            kbd_cmd_pkg::CMD_SELF_TEST: begin
              next_st_cnt  = 16'h0000;
              next_st_done = 1'b0;
              next_st_code = kbd_cmd_pkg::ERR_NONE;
              next_state   = SELF_TEST;
            end
            kbd_cmd_pkg::CMD_READ_INPUT: begin
              next_out_reg = input_port;
              load         = 1'b1;
            end
            default: ;
          endcase
        end
      end
      CHECK: begin
        if (lc.done) begin
          next_out_reg = lc.code;
          load         = 1'b1;
          next_state   = IDLE;
        end
      end
      SELF_TEST: begin
        next_st_cnt = st_cnt + 16'h0001;
        if (st_cnt == 16'(ST_CYC - 1)) begin
          next_st_done = 1'b1;
          next_state   = IDLE;
          if (self_test_fault) begin
            next_st_code = self_test_fault_code;
          end else begin
            next_st_code = kbd_cmd_pkg::ERR_PASS_DONE;
            next_out_reg = kbd_cmd_pkg::SELF_TEST_PASS;
            load         = 1'b1;
          end
        end
      end
      default: next_state = IDLE;
    endcase
    // A load in the same cycle as a read keeps the flag set.
    next_full = load ? 1'b1 : (out_read ? 1'b0 : full);
  end

  // Sequencer registers.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= IDLE;
      cmd_reg   <= kbd_cmd_pkg::CMD_BYTE_RESET;
      out_reg   <= 8'h00;
      full      <= 1'b0;
      st_code   <= kbd_cmd_pkg::ERR_NONE;
      st_done   <= 1'b0;
      sel_aux   <= 1'b0;
      chk_start <= 1'b0;
      st_cnt    <= 16'h0000;
    end else begin
      state     <= next_state;
      cmd_reg   <= next_cmd_reg;
      out_reg   <= next_out_reg;
      full      <= next_full;
      st_code   <= next_st_code;
      st_done   <= next_st_done;
      sel_aux   <= next_sel_aux;
      chk_start <= next_chk_start;
      st_cnt    <= next_st_cnt;
    end
  end

  assign lc.start   = chk_start;
  assign lc.sel_aux = sel_aux;

  ////////////////////////////////////////////////////////////////////////////////
  // Pin drive: outputs always low, enable (active low) pulls the open-drain line.
  assign kbd_clk_out  = 1'b0;
  assign kbd_dat_out  = 1'b0;
  assign aux_clk_out  = 1'b0;
  assign aux_dat_out  = 1'b0;
  assign kbd_clk_oe_n = ~((lc.drive_clk_low & ~sel_aux) | cmd_reg[kbd_cmd_pkg::KBD_DIS_BIT]);
  assign kbd_dat_oe_n = ~(lc.drive_dat_low & ~sel_aux);
  assign aux_clk_oe_n = ~((lc.drive_clk_low & sel_aux)
                        | (cmd_reg[kbd_cmd_pkg::AUX_DIS_BIT] & ~lc.busy));
  assign aux_dat_oe_n = ~(lc.drive_dat_low & sel_aux);

  // Status outputs.
  assign out_data         = out_reg;
  assign output_full_flag = full | st_done;
  assign status_code      = st_code;
  assign command_byte     = cmd_reg;
  assign kbd_enabled      = ~cmd_reg[kbd_cmd_pkg::KBD_DIS_BIT];
  assign busy             = (state != IDLE);
endmodule

// file: dv/kbd_cmd_chk.sv
// Concurrent checks on the ports of the keyboard/mouse command decoder.
module kbd_cmd_chk #(
  parameter int ST_CYC = 16
) (
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire logic       cmd_write,
  input wire logic [7:0] cmd_data,
  input wire logic       out_read,
  input wire logic [7:0] input_port,
  input wire logic       aux_clk_oe_n,
  input wire logic [7:0] out_data,
  input wire logic       output_full_flag,
  input wire logic [3:0] status_code,
  input wire logic [7:0] command_byte,
  input wire logic       kbd_enabled,
  input wire logic       busy
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int ST_D = ST_CYC + 1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // A command is taken only while the sequencer is idle.
  wire take = cmd_write && !busy;
  //////////////////////////////////////////////////////////////////////////////
  aux_on_a: assert property (take && cmd_data == 8'hA8 |=> !command_byte[5])
    else $error("mouse enable left its bit set");
  aux_off_a: assert property (take && cmd_data == 8'hA7 |=> command_byte[5] && !aux_clk_oe_n)
    else $error("mouse disable did not hold the clock low");
  kbd_off_a: assert property (take && cmd_data == 8'hAD |=> command_byte[4] && !kbd_enabled)
    else $error("keyboard disable not applied");
  kbd_on_a: assert property (take && cmd_data == 8'hAE |=> !command_byte[4] && kbd_enabled)
    else $error("keyboard enable not applied");
  port_read_a: assert property (take && cmd_data == 8'hC0 |=>
    out_data == $past(input_port) && output_full_flag) else $error("port byte not loaded");
  test_end_a: assert property (take && cmd_data == 8'hAA |-> ##[1:ST_D] output_full_flag)
    else $error("self-test did not finish in time");
  test_pass_a: assert property ($rose(status_code == 4'h8) |-> out_data == 8'h55)
    else $error("pass status without pass byte");
  seq_end_a: assert property ($fell(busy) |-> output_full_flag)
    else $error("sequence ended without a result");
  read_clear_a: assert property (out_read && !cmd_write && !busy && status_code == 4'h0
    |=> !output_full_flag) else $error("host read did not empty the output");
  bad_code_a: assert property (take && cmd_data == 8'hA4 |=>
    $stable(command_byte) && $stable(out_data)) else $error("reserved code changed state");
  busy_drop_a: assert property (cmd_write && busy && cmd_data == 8'hAD |=>
    $stable(command_byte)) else $error("command taken while busy");
endmodule

// file: dv/ps2_line_model.sv
// Far-side model of one open-drain line with a pull-up and fault injection.
module ps2_line_model (
  input  wire logic       oe_n,
  input  wire logic [1:0] stuck,
  output logic            level
);
  timeunit 1ns;
  timeprecision 1ns;
  // Mode 1 holds the line low, mode 2 high; otherwise the pull-up wins unless pulled.
  assign level = (stuck == 2'h1) ? 1'b0 : (stuck == 2'h2) ? 1'b1 : oe_n;
endmodule

// file: dv/kbd_mouse_cmd_decode_test.sv
// Self-checking bench for the keyboard/mouse command decoder.
module kbd_mouse_cmd_decode_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int         SETTLE = 8;
  localparam int         ST_CYC = 16;
  localparam logic [7:0] mode_code [4] = '{8'hA7, 8'hA8, 8'hAD, 8'hAE};
  localparam logic [7:0] mode_exp [4]  = '{8'h20, 8'h00, 8'h10, 8'h00};
  localparam logic [3:0] mode_oe [4]   = '{4'hB, 4'hF, 4'hE, 4'hF};
  logic       ref_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       cmd_write = 1'b0;
  logic [7:0] cmd_data = 8'h00;
  logic       out_read = 1'b0;
  logic [7:0] input_port = 8'hC3;
  logic       self_test_fault = 1'b0;
  logic [3:0] self_test_fault_code = 4'h0;
  logic [1:0] stuck [4] = '{default: 2'h0};
  wire  [3:0] oe_n;
  wire  [3:0] lvl;
  wire  [3:0] drv;
  logic [7:0] out_data;
  logic [7:0] command_byte;
  logic       output_full_flag;
  logic       kbd_enabled;
  logic       busy;
  logic [3:0] status_code;
  int         n_fail = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  //////////////////////////////////////////////////////////////////////////////
  // Lines 0..3 are keyboard clock, keyboard data, mouse clock, mouse data.
  for (genvar i = 0; i < 4; i++) begin : g_line
    ps2_line_model line (.oe_n(oe_n[i]), .stuck(stuck[i]), .level(lvl[i]));
  end
  kbd_mouse_cmd_decode #(.SETTLE(SETTLE), .ST_CYC(ST_CYC)) uut (
    .ref_clk, .arst_n, .cmd_write, .cmd_data, .out_read, .input_port, .self_test_fault,
    .self_test_fault_code, .kbd_clk_in(lvl[0]), .kbd_dat_in(lvl[1]), .aux_clk_in(lvl[2]),
    .aux_dat_in(lvl[3]), .kbd_clk_oe_n(oe_n[0]), .kbd_dat_oe_n(oe_n[1]),
    .aux_clk_oe_n(oe_n[2]), .aux_dat_oe_n(oe_n[3]), .kbd_clk_out(drv[0]),
    .kbd_dat_out(drv[1]), .aux_clk_out(drv[2]), .aux_dat_out(drv[3]), .out_data,
    .output_full_flag, .status_code,
    .command_byte, .kbd_enabled, .busy);
  // The clock toggles every half period of 5 ns.
  always #5 ref_clk = ~ref_clk;
  // A hung run is cut short well past the expected length.
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      n_fail++;
      results();
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic send(input logic [7:0] code);
    @(posedge ref_clk);
    cmd_write <= 1'b1;
    cmd_data  <= code;
    @(posedge ref_clk);
    cmd_write <= 1'b0;
    #1;
  endtask
  task automatic rd();
    @(posedge ref_clk);
    out_read <= 1'b1;
    @(posedge ref_clk);
    out_read <= 1'b0;
    #1;
  endtask
  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 400) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    check("busy", {7'h00, busy}, 8'h00);
  endtask
  task automatic results();
    $display("Compares %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Main sequence: mode bits, port read, reserved code, line checks, self-tests.
  initial begin
    repeat (12) @(posedge ref_clk);
    arst_n <= 1'b1;
    #1;
    check("cmd_byte", command_byte, 8'h00);
    check("oe_n", {4'h0, oe_n}, 8'h0F);
    check("drive", {4'h0, drv}, 8'h00);
    for (int i = 0; i < 4; i++) begin
      send(mode_code[i]);
      check("cmd_byte", command_byte, mode_exp[i]);
      check("oe_n", {4'h0, oe_n}, {4'h0, mode_oe[i]});
      check("kbd_en", {7'h00, kbd_enabled}, {7'h00, ~mode_exp[i][4]});
    end
    send(8'hC0);
    check("out_data", out_data, 8'hC3);
    check("full", {7'h00, output_full_flag}, 8'h01);
    rd();
    check("full", {7'h00, output_full_flag}, 8'h00);
    send(8'hA4);
    check("out_data", out_data, 8'hC3);
    check("full", {7'h00, output_full_flag}, 8'h00);
    for (int s = 0; s < 2; s++) begin
      for (int m = 0; m < 5; m++) begin
        stuck[2*s]   = (m == 1) ? 2'h1 : (m == 2) ? 2'h2 : 2'h0;
        stuck[2*s+1] = (m == 3) ? 2'h1 : (m == 4) ? 2'h2 : 2'h0;
        repeat (4) @(posedge ref_clk);
        send((s == 0) ? 8'hAB : 8'hA9);
        idle();
        check("line_code", out_data, 8'(m));
        check("full", {7'h00, output_full_flag}, 8'h01);
        rd();
      end
      stuck[2*s+1] = 2'h0;
    end
    for (int k = 0; k < 7; k++) begin
      @(posedge ref_clk);
      self_test_fault      <= (k != 0);
      self_test_fault_code <= 4'(k);
      send(8'hAA);
      if (k == 0)
        send(8'hAD);
      idle();
      check("status", {4'h0, status_code}, (k != 0) ? 8'(k) : 8'h08);
      check("full", {7'h00, output_full_flag}, 8'h01);
      if (k == 0)
        check("out_data", out_data, 8'h55);
      if (k == 0)
        check("cmd_byte", command_byte, 8'h00);
    end
    results();
  end
endmodule

bind kbd_mouse_cmd_decode kbd_cmd_chk #(.ST_CYC(ST_CYC)) chk (.ref_clk, .arst_n, .cmd_write,
  .cmd_data, .out_read, .input_port, .aux_clk_oe_n, .out_data, .output_full_flag,
  .status_code, .command_byte, .kbd_enabled, .busy);
